// File: src/epr_pkg.sv
// Constants for the parallel port register and FIFO front end
package epr_pkg;
    localparam logic [10:0] OFS_DATA = 11'h000;
    localparam logic [10:0] OFS_STATUS = 11'h001;
    localparam logic [10:0] OFS_CONTROL = 11'h002;
    localparam logic [10:0] OFS_FIFO = 11'h400;
    localparam logic [10:0] OFS_CFG_B = 11'h401;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam logic [7:0] CFG_A_VALUE = 8'h10;
    localparam int CTRL_STROBE = 0;
    localparam int CTRL_AUTOFD = 1;
    localparam int CTRL_INIT = 2;
    localparam int CTRL_SELIN = 3;
    localparam int CTRL_ACKIE = 4;
    localparam int CTRL_DIR = 5;
    localparam logic [2:0] MODE_STD = 3'h0;
    localparam logic [2:0] MODE_BIDIR = 3'h1;
    localparam logic [2:0] MODE_COMPAT = 3'h2;
    localparam logic [2:0] MODE_ECP = 3'h3;
    localparam logic [2:0] MODE_EPP = 3'h4;
    localparam logic [2:0] MODE_TEST = 3'h6;
    localparam logic [2:0] MODE_CFG = 3'h7;
    localparam int CLK_MHZ = 200;
    localparam int STROBE_SETUP_NS = 500;
    localparam int STROBE_SETUP_CYC = (STROBE_SETUP_NS * CLK_MHZ + 999) / 1000;
    typedef enum logic [2:0] {HS_IDLE, HS_SETUP, HS_STROBE, HS_RELEASE, HS_RX_ACK} epr_hs_t;
endpackage

// File: src/epr_port.sv
// Parallel port host registers, shared FIFO and automatic port handshake
module epr_port
    import epr_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int FREE_THR = 8,
    parameter int FILL_THR = 8,
    parameter logic [2:0] IRQ_SEL = 3'h0,
    parameter logic [2:0] DMA_SEL = 3'h0
) (
    input wire logic ref_clk, // System clock
    input wire logic rst_n, // Async reset
    input wire logic [10:0] addr, // Register offset
    input wire logic wr_en, // Host write strobe
    input wire logic rd_en, // Host read strobe
    input wire logic [7:0] wr_data, // Host write byte
    output logic [7:0] rd_data, // Read byte, next cycle
    input wire logic [2:0] mode, // Mode field
    input wire logic service_clear, // Clears service flag
    output logic service_request_flag, // Service flag
    output logic fifo_full, // FIFO full
    output logic fifo_empty, // FIFO empty
    output logic irq, // Interrupt pulse
    input wire logic [7:0] port_data_in, // Sampled data lines
    output logic [7:0] port_data_out, // Driven data lines
    output logic port_data_oe, // Data lines driven
    output logic strobe_n, // nStrobe
    output logic auto_fd_n, // nAutoFd / HostAck
    output logic init_n, // nInit
    output logic select_in_n, // nSelectIn
    input wire logic fault_n, // nFault
    input wire logic select, // Select
    input wire logic perror, // PError
    input wire logic ack_n, // nAck
    input wire logic busy // Busy
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
    localparam logic [CW-1:0] FREE_C = CW'(FREE_THR);
    localparam logic [CW-1:0] FILL_C = CW'(FILL_THR);
    localparam logic [7:0] SETUP_C = 8'(STROBE_SETUP_CYC);

    // Pointers wrap by bit width, so only powers of two are served
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || FREE_THR < 1 || FREE_THR > DEPTH ||
        FILL_THR < 1 || FILL_THR > DEPTH || STROBE_SETUP_CYC > 255) begin : g_bad
        $error("epr_port: unsupported parameter values");
    end

    logic [7:0] data_latch;
    logic [5:0] ctrl;
    logic [8:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic [7:0] last_rd;
    logic ack_prev;
    logic [7:0] tx_byte;
    logic tx_tag;
    logic [7:0] setup_cnt;
    epr_hs_t hs;
    epr_hs_t next_hs;

    // Mode decode
    wire is_std = (mode == MODE_STD);
    wire is_bidir = (mode == MODE_BIDIR);
    wire is_compat = (mode == MODE_COMPAT);
    wire is_ecp = (mode == MODE_ECP);
    wire is_test = (mode == MODE_TEST);
    wire is_cfg = (mode == MODE_CFG);
    wire dir_in = ctrl[CTRL_DIR] & ~(is_std | is_compat);
    wire tx_mode = is_compat | (is_ecp & ~dir_in);
    wire rx_mode = is_ecp & dir_in;
    wire flush = is_std | is_bidir;

    // Access decode; undefined mode/offset pairs fall through with no effect
    wire wr_data_reg = wr_en & (addr == OFS_DATA) & (is_std | is_bidir);
    wire wr_afifo = wr_en & (addr == OFS_DATA) & is_ecp & ~dir_in;
    wire wr_ctrl = wr_en & (addr == OFS_CONTROL);
    wire wr_fifo = wr_en & (addr == OFS_FIFO) & (tx_mode | is_test);
    wire rd_fifo = rd_en & (addr == OFS_FIFO) & (rx_mode | is_test);

    // FIFO control; host writes to a full FIFO are dropped without stalling, reverse bytes wait in HS_IDLE for space
    wire rx_take = (hs == HS_IDLE) & rx_mode & ~ack_n & ~fifo_full;
    wire tx_take = (hs == HS_IDLE) & tx_mode & ~fifo_empty & ~busy;
    wire push = (wr_afifo | wr_fifo | rx_take) & ~fifo_full;
    wire pop = (rd_fifo | tx_take) & ~fifo_empty;
    wire [8:0] push_word = rx_take ? {1'b0, port_data_in} : {wr_afifo, wr_data};
    wire [8:0] head = mem[rd_ptr];
    assign fifo_full = (count == DEPTH_C);
    assign fifo_empty = (count == '0);

    // Service flag; a set in the clearing cycle wins
    wire [CW-1:0] free_bytes = DEPTH_C - count;
    wire svc_mode = is_compat | is_ecp | is_test;
    wire svc_cond = dir_in ? (count >= FILL_C) : (free_bytes >= FREE_C);
    wire svc_hit = svc_mode & svc_cond & (~service_request_flag | service_clear);
    wire ack_rise = ack_n & ~ack_prev;

    // Read data selection
    wire [7:0] status_val = {~busy, ack_n, perror, select, fault_n, 3'h0};
    wire [7:0] fifo_rd_val = fifo_empty ? last_rd : head[7:0];
    wire [7:0] cfg_b_val = {1'b0, irq, IRQ_SEL, DMA_SEL};
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (addr == OFS_DATA && (is_std || is_bidir)) begin
            rd_mux = port_data_in;
        end else if (addr == OFS_STATUS) begin
            rd_mux = status_val;
        end else if (addr == OFS_CONTROL) begin
            rd_mux = {2'h0, ctrl};
        end else if (addr == OFS_FIFO && is_cfg) begin
            rd_mux = CFG_A_VALUE;
        end else if (rd_fifo) begin
            rd_mux = fifo_rd_val;
        end else if (addr == OFS_CFG_B && is_cfg) begin
            rd_mux = cfg_b_val;
        end
    end

    // Handshake sequencing; leaving the auto modes aborts a transfer
    always_comb begin
        next_hs = hs;
        case (hs)
            HS_IDLE: begin
                if (tx_take) next_hs = HS_SETUP;
                else if (rx_take) next_hs = HS_RX_ACK;
            end
            HS_SETUP: if (setup_cnt == 8'h00) next_hs = HS_STROBE;
            HS_STROBE: if (busy) next_hs = HS_RELEASE;
            HS_RELEASE: if (!busy) next_hs = HS_IDLE;
            HS_RX_ACK: if (ack_n) next_hs = HS_IDLE;
            default: next_hs = HS_IDLE;
        endcase
        if (!(tx_mode || rx_mode)) next_hs = HS_IDLE;
    end

    // Data lines: latch in SPP modes, head in test mode, sent byte otherwise
    wire [7:0] next_pdo = (is_std | is_bidir) ? data_latch : (is_test ? head[7:0] : tx_byte);

    // Control lines; the automatic handshake owns nStrobe, and nAutoFd in ECP mode only
    wire hs_tx_busy = (hs == HS_SETUP) | (hs == HS_STROBE) | (hs == HS_RELEASE);
    assign strobe_n = hs_tx_busy ? (hs != HS_STROBE) : ~ctrl[CTRL_STROBE];
    assign auto_fd_n = (hs_tx_busy && is_ecp) ? ~tx_tag :
                       rx_mode ? (hs == HS_RX_ACK) : ~ctrl[CTRL_AUTOFD];
    assign select_in_n = ~ctrl[CTRL_SELIN];
    assign init_n = ctrl[CTRL_INIT];
    assign port_data_oe = ~dir_in;

    // Host registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_latch <= DATA_RESET;
            ctrl <= CTRL_RESET;
            rd_data <= 8'h00;
            port_data_out <= 8'h00;
        end else begin
            if (wr_data_reg) data_latch <= wr_data;
            if (wr_ctrl) ctrl <= wr_data[5:0];
            if (rd_en) rd_data <= rd_mux;
            port_data_out <= next_pdo;
        end
    end

    // FIFO storage
    always_ff @(posedge ref_clk) begin
        if (push) mem[wr_ptr] <= push_word;
    end

    // FIFO pointers; SPP modes hold it empty
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            last_rd <= 8'h00;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + AW'(1);
            if (pop) rd_ptr <= rd_ptr + AW'(1);
            count <= count + CW'(push) - CW'(pop);
            if (rd_fifo && pop) last_rd <= head[7:0];
        end
    end

    // Service flag and interrupt pulse
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            service_request_flag <= 1'b0;
            irq <= 1'b0;
            ack_prev <= 1'b1;
        end else begin
            service_request_flag <= svc_hit | (service_request_flag & ~service_clear);
            irq <= (ack_rise & ctrl[CTRL_ACKIE]) | svc_hit;
            ack_prev <= ack_n;
        end
    end

    // Handshake state
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hs <= HS_IDLE;
            tx_byte <= 8'h00;
            tx_tag <= 1'b0;
            setup_cnt <= 8'h00;
        end else begin
            hs <= next_hs;
            if (tx_take) begin
                tx_byte <= head[7:0];
                tx_tag <= head[8];
                setup_cnt <= SETUP_C - 8'h01;
            end else if (hs == HS_SETUP && setup_cnt != 8'h00) begin
                setup_cnt <= setup_cnt - 8'h01;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_latch_write;
        wr_data_reg && is_std ##1 is_std;
    endsequence
    property p_data_drive;
        s_latch_write |=> port_data_out == $past(wr_data, 2);
    endproperty
    a_data_drive: assert property (p_data_drive) else $error("data latch not on lines");

    property p_status_read;
        rd_en && addr == OFS_STATUS |=> rd_data[2:0] == 3'h0 && rd_data[7] == !$past(busy)
            && rd_data[6] == $past(ack_n) && rd_data[3] == $past(fault_n);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    property p_ctrl_top;
        rd_en && addr == OFS_CONTROL |=> rd_data[7:6] == 2'h0;
    endproperty
    a_ctrl_top: assert property (p_ctrl_top) else $error("control top bits set");

    property p_ctrl_lines;
        wr_ctrl && is_std ##1 is_std |-> strobe_n == !$past(wr_data[0]) && init_n == $past(wr_data[2]);
    endproperty
    a_ctrl_lines: assert property (p_ctrl_lines) else $error("control lines wrong");

    property p_ack_irq;
        ctrl[CTRL_ACKIE] && $rose(ack_n) |=> irq;
    endproperty
    a_ack_irq: assert property (p_ack_irq) else $error("ack interrupt missing");

    property p_full_drop;
        is_test && wr_fifo && fifo_full && !rd_fifo |=> fifo_full && count == $past(count);
    endproperty
    a_full_drop: assert property (p_full_drop) else $error("full FIFO accepted write");

    property p_empty_reread;
        is_test && rd_fifo && fifo_empty && !wr_en |=> rd_data == $past(last_rd) && fifo_empty;
    endproperty
    a_empty_reread: assert property (p_empty_reread) else $error("empty reread wrong");

    property p_svc_set;
        svc_mode && !dir_in && free_bytes >= FREE_C && !service_request_flag
            |=> service_request_flag && irq;
    endproperty
    a_svc_set: assert property (p_svc_set) else $error("service flag not set");

    property p_cfg_a;
        rd_en && is_cfg && addr == OFS_FIFO |=> rd_data == CFG_A_VALUE;
    endproperty
    a_cfg_a: assert property (p_cfg_a) else $error("config A value wrong");

    property p_dir_out;
        is_std || is_compat |-> port_data_oe;
    endproperty
    a_dir_out: assert property (p_dir_out) else $error("data lines not driven");

    property p_line_read;
        rd_en && addr == OFS_DATA && (is_std || is_bidir) |=> rd_data == $past(port_data_in);
    endproperty
    a_line_read: assert property (p_line_read) else $error("bad line read");

    property p_afifo_push;
        wr_afifo && !fifo_full |=> mem[$past(wr_ptr)] == {1'b1, $past(wr_data)};
    endproperty
    a_afifo_push: assert property (p_afifo_push) else $error("addr untagged");

    property p_status_mid;
        rd_en && addr == OFS_STATUS |=> rd_data[5:4] == {$past(perror), $past(select)};
    endproperty
    a_status_mid: assert property (p_status_mid) else $error("status mid bits");

    property p_busy_bit;
        rd_en && addr == OFS_STATUS |=> rd_data[7] != $past(busy);
    endproperty
    a_busy_bit: assert property (p_busy_bit) else $error("busy bit wrong");

    property p_ctrl_store;
        wr_ctrl |=> ctrl == $past(wr_data[5:0]);
    endproperty
    a_ctrl_store: assert property (p_ctrl_store) else $error("ctrl not stored");

    property p_selin;
        wr_ctrl |=> select_in_n == !$past(wr_data[CTRL_SELIN]);
    endproperty
    a_selin: assert property (p_selin) else $error("select line wrong");

    // A take only counts when the mode still holds one cycle later
    sequence s_compat_take;
        tx_take && is_compat ##1 is_compat;
    endsequence
    property p_compat_send;
        s_compat_take |=> port_data_out == $past(head[7:0], 2) && strobe_n;
    endproperty
    a_compat_send: assert property (p_compat_send) else $error("bad compat out");

    sequence s_ecp_take;
        tx_take && is_ecp ##1 is_ecp;
    endsequence
    property p_ecp_tag;
        s_ecp_take |-> auto_fd_n == !$past(head[8]) && strobe_n;
    endproperty
    a_ecp_tag: assert property (p_ecp_tag) else $error("ecp tag wrong");

    property p_rx_push;
        rx_take |=> mem[$past(wr_ptr)] == {1'b0, $past(port_data_in)};
    endproperty
    a_rx_push: assert property (p_rx_push) else $error("rx byte lost");

    property p_test_quiet;
        is_test ##1 is_test |-> hs == HS_IDLE && strobe_n == !ctrl[CTRL_STROBE];
    endproperty
    a_test_quiet: assert property (p_test_quiet) else $error("test handshake");

    property p_head_order;
        rd_fifo && !fifo_empty
            |=> rd_data == $past(head[7:0]) && rd_ptr == $past(rd_ptr) + AW'(1);
    endproperty
    a_head_order: assert property (p_head_order) else $error("fifo order");

    property p_fill_set;
        svc_mode && dir_in && count >= FILL_C && !service_request_flag
            |=> service_request_flag && irq;
    endproperty
    a_fill_set: assert property (p_fill_set) else $error("fill flag not set");

    property p_cfg_b;
        rd_en && is_cfg && addr == OFS_CFG_B |=> rd_data[7:6] == {1'b0, $past(irq)};
    endproperty
    a_cfg_b: assert property (p_cfg_b) else $error("config B wrong");

    // Only software may drop the flag, or a pending service would be lost
    property p_flag_hold;
        service_request_flag && !service_clear |=> service_request_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

    property p_undef;
        rd_en && mode == MODE_EPP && (addr == OFS_DATA || addr == OFS_FIFO)
            |=> rd_data == 8'h00 && count == $past(count);
    endproperty
    a_undef: assert property (p_undef) else $error("undefined access");
endmodule

// File: dv/epr_printer_model.sv
// Printer-side behavioural model of the parallel port lines
module epr_printer_model (
    input wire logic ref_clk, // System clock
    input wire logic strobe_n, // Data strobe
    input wire logic auto_fd_n, // Tag or host ack
    input wire logic [7:0] port_data_out, // Device data
    input wire logic port_data_oe, // Device drives lines
    output logic [7:0] port_data_in, // Resolved lines
    output logic busy, // Busy
    output logic ack_n // nAck
);
    timeunit 1ns;
    timeprecision 100ps;
    logic fwd_en = 1'b0;
    logic rev_drive = 1'b0;
    logic [7:0] rev_data = 8'h00;
    int lag = 3;
    int cnt = 0;
    logic [8:0] got[$];
    initial begin
        busy = 1'b0;
        ack_n = 1'b1;
    end
    // Released lines show the inverse, so stale data never looks valid
    assign port_data_in = port_data_oe ? port_data_out : (rev_drive ? rev_data : ~rev_data);
    // Forward: take byte after a lag, hold busy until strobe lets go
    always @(posedge ref_clk) begin
        if (fwd_en && !strobe_n && !busy) begin
            cnt <= cnt + 1;
            if (cnt >= lag) begin
                got.push_back({auto_fd_n, port_data_out});
                busy <= 1'b1;
                cnt <= 0;
            end
        end else if (fwd_en && strobe_n && busy) begin
            busy <= 1'b0;
        end
    end
    // Reverse: present byte, interlock ack_n with auto_fd_n
    task automatic send(input logic [7:0] b);
        @(posedge ref_clk);
        #1;
        rev_data = b;
        rev_drive = 1'b1;
        ack_n = 1'b0;
        for (int i = 0; i < 50 && auto_fd_n !== 1'b1; i++) @(posedge ref_clk);
        #1;
        ack_n = 1'b1;
        for (int i = 0; i < 50 && auto_fd_n !== 1'b0; i++) @(posedge ref_clk);
        #1;
        rev_drive = 1'b0;
    endtask
endmodule

// File: dv/ecp_parallel_port_regs_test.sv
// Self-checking bench for the parallel port register front end
module ecp_parallel_port_regs_test;
    import epr_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, service_clear = 1'b0;
    logic [10:0] addr = 11'h000;
    logic [7:0] wr_data = 8'h00, rd_data, pdi, pdo, r;
    logic [2:0] mode = 3'h0;
    logic flag, full, empty, irq, oe, strobe_n, auto_fd_n, init_n, select_in_n, busy, ack_n;
    logic fault_n = 1'b1, select = 1'b1, perror = 1'b0;
    int miscompares = 0, cmp_count = 0;
    epr_port i_epr_port (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wr_en(wr_en),
        .rd_en(rd_en), .wr_data(wr_data), .rd_data(rd_data), .mode(mode),
        .service_clear(service_clear), .service_request_flag(flag), .fifo_full(full),
        .fifo_empty(empty), .irq(irq), .port_data_in(pdi), .port_data_out(pdo),
        .port_data_oe(oe), .strobe_n(strobe_n), .auto_fd_n(auto_fd_n), .init_n(init_n),
        .select_in_n(select_in_n), .fault_n(fault_n), .select(select), .perror(perror),
        .ack_n(ack_n), .busy(busy));
    epr_printer_model i_printer (.ref_clk(ref_clk), .strobe_n(strobe_n),
        .auto_fd_n(auto_fd_n), .port_data_out(pdo), .port_data_oe(oe), .port_data_in(pdi),
        .busy(busy), .ack_n(ack_n));
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // Bus cycles: one-cycle strobes, read answer lands one edge later
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        addr = a;
        wr_data = d;
        wr_en = 1'b1;
        @(posedge ref_clk);
        #1;
        wr_en = 1'b0;
    endtask
    task automatic rd(input logic [10:0] a);
        @(posedge ref_clk);
        #1;
        addr = a;
        rd_en = 1'b1;
        @(posedge ref_clk);
        #1;
        rd_en = 1'b0;
        r = rd_data;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic clr();
        service_clear = 1'b1;
        cyc(1);
        service_clear = 1'b0;
    endtask
    task automatic t_ctrl();
        rd(OFS_CONTROL);
        chk(r, 8'h00, "ctrl reset");
        chk({4'h0, strobe_n, auto_fd_n, init_n, select_in_n}, 8'h0D, "lines reset");
        chk(pdo, DATA_RESET, "latch reset");
        wr(OFS_CONTROL, 8'hFF);
        rd(OFS_CONTROL);
        chk(r, 8'h3F, "ctrl ff");
        chk({4'h0, strobe_n, auto_fd_n, init_n, select_in_n}, 8'h02, "lines set");
        wr(OFS_CONTROL, 8'h00);
        $display("ctrl done");
    endtask
    task automatic t_data();
        wr(OFS_CONTROL, 8'h20);
        wr(OFS_DATA, 8'hA5);
        cyc(1);
        chk(pdo, 8'hA5, "latch out");
        chk({7'h0, oe}, 8'h01, "dir ignored");
        rd(OFS_DATA);
        chk(r, 8'hA5, "line read");
        mode = MODE_BIDIR;
        i_printer.rev_data = 8'h3C;
        i_printer.rev_drive = 1'b1;
        cyc(2);
        chk({7'h0, oe}, 8'h00, "dir in");
        rd(OFS_DATA);
        chk(r, 8'h3C, "lines not latch");
        i_printer.rev_drive = 1'b0;
        mode = MODE_STD;
        wr(OFS_CONTROL, 8'h00);
        $display("data done");
    endtask
    task automatic t_status();
        fault_n = 1'b0;
        i_printer.busy = 1'b0;
        cyc(2);
        rd(OFS_STATUS);
        chk(r, 8'hD0, "status a");
        {fault_n, select, perror} = 3'b101;
        i_printer.ack_n = 1'b0;
        i_printer.busy = 1'b1;
        cyc(2);
        rd(OFS_STATUS);
        chk(r, 8'h28, "status b");
        $display("status done");
    endtask
    task automatic t_ack(input logic [7:0] c, input logic exp);
        logic seen;
        seen = 1'b0;
        wr(OFS_CONTROL, c);
        i_printer.ack_n = 1'b0;
        cyc(2);
        i_printer.ack_n = 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            #1;
            seen = seen | irq;
        end
        chk({7'h0, seen}, {7'h0, exp}, "ack irq");
        $display("ack done");
    endtask
    task automatic t_loopback_test_fifo();
        wr(OFS_CONTROL, 8'h00);
        mode = MODE_TEST;
        for (int i = 0; i < 17; i++) wr(OFS_FIFO, 8'h40 + 8'(i));
        chk({6'h0, full, empty}, 8'h02, "full");
        chk({7'h0, strobe_n}, 8'h01, "no strobe");
        clr();
        for (int i = 0; i < 8; i++) begin
            cyc(2);
            chk({7'h0, flag}, 8'h00, "flag early");
            rd(OFS_FIFO);
            chk(r, 8'h40 + 8'(i), "head");
        end
        cyc(2);
        chk({7'h0, flag}, 8'h01, "free thr");
        for (int i = 8; i < 16; i++) begin
            rd(OFS_FIFO);
            chk(r, 8'h40 + 8'(i), "tail");
        end
        rd(OFS_FIFO);
        chk(r, 8'h4F, "reread");
        chk({6'h0, full, empty}, 8'h01, "empty");
        wr(OFS_CONTROL, 8'h20);
        clr();
        for (int i = 0; i < 8; i++) begin
            cyc(2);
            chk({7'h0, flag}, 8'h00, "fill early");
            wr(OFS_FIFO, 8'(i));
        end
        cyc(2);
        chk({7'h0, flag}, 8'h01, "fill thr");
        mode = MODE_STD;
        $display("loopback_test_fifo done");
    endtask
    task automatic t_cfg();
        mode = MODE_CFG;
        wr(OFS_FIFO, 8'h55);
        rd(OFS_FIFO);
        chk(r, CFG_A_VALUE, "cfg a");
        rd(OFS_CFG_B);
        chk(r & 8'hBF, 8'h00, "cfg b");
        rd(11'h003);
        chk(r, 8'h00, "unmapped");
        mode = MODE_EPP;
        rd(OFS_FIFO);
        chk(r, 8'h00, "epp fifo");
        mode = MODE_STD;
        $display("cfg done");
    endtask
    task automatic t_fwd();
        // Standard mode for one write flushes stale bytes and sets direction out
        wr(OFS_CONTROL, 8'h00);
        i_printer.busy = 1'b0;
        i_printer.fwd_en = 1'b1;
        mode = MODE_COMPAT;
        wr(OFS_FIFO, 8'h5A);
        wr(OFS_FIFO, 8'hC3);
        for (int i = 0; i < 3000 && i_printer.got.size() < 2; i++) cyc(1);
        mode = MODE_ECP;
        i_printer.lag = 40;
        wr(OFS_DATA, 8'hA1);
        wr(OFS_FIFO, 8'hD2);
        for (int i = 0; i < 3000 && i_printer.got.size() < 4; i++) cyc(1);
        chk(8'(i_printer.got.size()), 8'h04, "count");
        chk(i_printer.got[0][7:0], 8'h5A, "compat 0");
        chk(i_printer.got[1][7:0], 8'hC3, "compat 1");
        chk({7'h0, i_printer.got[2][8]}, 8'h00, "addr tag");
        chk(i_printer.got[2][7:0], 8'hA1, "addr");
        chk({7'h0, i_printer.got[3][8]}, 8'h01, "data tag");
        chk(i_printer.got[3][7:0], 8'hD2, "data");
        i_printer.fwd_en = 1'b0;
        mode = MODE_BIDIR;
        wr(OFS_CONTROL, 8'h20);
        mode = MODE_ECP;
        i_printer.send(8'h96);
        i_printer.send(8'h69);
        rd(OFS_FIFO);
        chk(r, 8'h96, "rev 0");
        rd(OFS_FIFO);
        chk(r, 8'h69, "rev 1");
        $display("link done");
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #300000;
        miscompares++;
        results();
    end
    initial begin
        cyc(8);
        rst_n = 1'b1;
        t_ctrl();
        t_data();
        t_status();
        t_ack(8'h10, 1'b1);
        t_ack(8'h00, 1'b0);
        t_loopback_test_fifo();
        t_cfg();
        t_fwd();
        results();
    end
endmodule
